// ===== design/sbr_pkg.sv
// Purpose: Shared constants and types for the serial bit-rate and flags block
// Assumes: APB byte offsets, one register per aligned 32-bit word
// Notes:   Register data sits in the low byte; upper bits read as zero
package sbr_pkg;
	// Register byte offsets
	localparam logic [7:0] SBR_OFF_RATE  = 8'h00;
	localparam logic [7:0] SBR_OFF_FLAGS = 8'h04;
	localparam logic [7:0] SBR_OFF_DATA  = 8'h08;
	localparam logic [7:0] SBR_OFF_CTRL  = 8'h0C;
	localparam logic [7:0] SBR_OFF_IST   = 8'h10;
	localparam logic [7:0] SBR_OFF_IMASK = 8'h14;
	// Rate register fields
	localparam int SBR_PRE_LSB = 4;
	localparam int SBR_DIV_LSB = 0;
	localparam logic [7:0] SBR_RATE_MASK = 8'h77;
	localparam logic [7:0] SBR_RATE_RST  = 8'h00;
	// Flag register bit positions
	localparam int SBR_FLAG_RXF  = 7;
	localparam int SBR_FLAG_TEF  = 5;
	localparam int SBR_FLAG_MASTER_FAULT_FLAG = 4;
	// Control register bits
	localparam int SBR_CTRL_EN   = 6;
	localparam int SBR_CTRL_MASTER_SELECT = 4;
	localparam int SBR_CTRL_FEN  = 3;
	localparam int SBR_CTRL_SOE  = 1;
	localparam logic [7:0] SBR_CTRL_MASK = 8'h5A;
	localparam logic [7:0] SBR_CTRL_RST  = 8'h00;
	// Interrupt status / mask bits
	localparam int SBR_IRQ_RX   = 0;
	localparam int SBR_IRQ_TX   = 1;
	localparam int SBR_IRQ_MASTER_FAULT_FLAG = 2;
	localparam int SBR_IRQ_OVR  = 3;
	localparam logic [3:0] SBR_IRQ_RST = 4'h0;
	// Frame length in bits and last half-period edge index
	localparam int SBR_FRAME_BITS = 8;
	localparam logic [3:0] SBR_EDGE_LAST = 4'(2 * SBR_FRAME_BITS - 1);

	typedef enum logic [1:0] {
		SBR_IDLE   = 2'b00,
		SBR_SHIFT  = 2'b01,
		SBR_FINISH = 2'b11
	} sbr_state_e;
endpackage

// ===== design/sbr_baud_gen.sv
// Purpose: Prescaler plus power-of-two divider giving half bit-period ticks
// Assumes: Bus clock drives both stages; run low holds counters at zero
// Notes:   Full bit period is (pre_sel+1) * 2^(div_sel+1) bus cycles
`timescale 1ns/1ps
`default_nettype none
module sbr_baud_gen
	import sbr_pkg::*;
#(
	parameter int PRE_W = 3,
	parameter int DIV_W = 3
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             clk_en,
	input  wire logic             run,
	input  wire logic [PRE_W-1:0] pre_sel,
	input  wire logic [DIV_W-1:0] div_sel,
	output logic                  half_tick
);
	localparam int DCNT_W = (1 << DIV_W) - 1;

	if (PRE_W < 1 || PRE_W > 8 || DIV_W < 1 || DIV_W > 4) begin : g_chk
		$error("sbr_baud_gen: unsupported PRE_W or DIV_W");
	end

	logic [PRE_W-1:0]  pre_cnt_q;
	logic [DCNT_W-1:0] div_cnt_q;
	logic              pre_tick;
	logic [DCNT_W-1:0] div_last;

	// Prescale divides by field + 1
	assign pre_tick  = run && (pre_cnt_q == pre_sel);
	// Half period is 2^field prescaled ticks, so full ratio is 2^(field+1)
	assign div_last  = DCNT_W'((1 << div_sel) - 1);
	assign half_tick = pre_tick && (div_cnt_q == div_last);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pre_cnt_q <= '0;
			div_cnt_q <= '0;
		end else if (clk_en) begin
			if (!run || pre_tick)
				pre_cnt_q <= '0;
			else
				pre_cnt_q <= pre_cnt_q + 1'b1;
			if (!run || half_tick)
				div_cnt_q <= '0;
			else if (pre_tick)
				div_cnt_q <= div_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks: helper counts cycles between half ticks
	logic [11:0] gap_q;
	logic        seen_q;
	always_ff @(posedge ref_clk) begin
		if (!nrst || !run) begin
			gap_q  <= '0;
			seen_q <= 1'b0;
		end else if (clk_en) begin
			gap_q  <= half_tick ? 12'h000 : gap_q + 12'h001;
			seen_q <= seen_q | half_tick;
		end
	end

	a_half_period: assert property (@(posedge ref_clk) disable iff (!nrst)
		clk_en && run && half_tick && seen_q && $stable(pre_sel) &&
		$stable(div_sel) |->
		(gap_q + 12'h001) == (12'(pre_sel + 1) << div_sel))
		else $error("half bit period does not match prescale and divide");
endmodule // sbr_baud_gen
`default_nettype wire

// ===== design/sbr_top.sv
// Purpose: APB-reached rate generator, flags and byte shifter of an SPI port
// Assumes: All pins synchronous to ref_clk; clock mode: idle low, mid-bit
// Notes:   pready rises one cycle after setup; no wait beyond that
`timescale 1ns/1ps
`default_nettype none
module sbr_top
	import sbr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sclk_in,
	input  wire logic        sdi,
	input  wire logic        sel_in_n,
	output logic             sclk_out,
	output logic             sclk_oe,
	output logic             sdo,
	output logic             sel_out_n,
	output logic             sel_oe,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0]  rate_q, ctrl_q, tx_buf_q, rx_buf_q, shift_q;
	logic [3:0]  ist_q, imask_q, edge_q;
	logic        tx_full_q, rxf_q, master_fault_flag_q, rx_arm_q, tx_arm_q, master_fault_flag_arm_q;
	logic        rx_bit_q, sclk_in_q;
	sbr_state_e  state_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, sclk_q, sclk_oe_q, sdo_q;
	logic        sel_out_n_q, sel_oe_q, irq_q;

	////////////////////////////////////////////////////////////////////////
	// APB decode
	wire setup_w   = psel && !penable;
	wire acc_w     = psel && penable && pready_q;
	wire wr_w      = acc_w && pwrite;
	wire rd_w      = acc_w && !pwrite;
	wire hit_rate  = (paddr == SBR_OFF_RATE);
	wire hit_flags = (paddr == SBR_OFF_FLAGS);
	wire hit_data  = (paddr == SBR_OFF_DATA);
	wire hit_ctrl  = (paddr == SBR_OFF_CTRL);
	wire hit_ist   = (paddr == SBR_OFF_IST);
	wire hit_imask = (paddr == SBR_OFF_IMASK);
	wire mapped_w  = hit_rate | hit_flags | hit_data | hit_ctrl |
		hit_ist | hit_imask;

	wire en_w     = ctrl_q[SBR_CTRL_EN];
	wire master_w = en_w && ctrl_q[SBR_CTRL_MASTER_SELECT];
	wire slave_w  = en_w && !ctrl_q[SBR_CTRL_MASTER_SELECT];
	wire tef_w    = !tx_full_q;

	logic [7:0] flags_w;
	// Unused positions hard-wired low
	assign flags_w = {rxf_q, 1'b0, tef_w, master_fault_flag_q, 4'h0};

	wire [31:0] rdata_w =
		hit_rate  ? {24'h00_0000, rate_q}   :
		hit_flags ? {24'h00_0000, flags_w}  :
		hit_data  ? {24'h00_0000, rx_buf_q} :
		hit_ctrl  ? {24'h00_0000, ctrl_q}   :
		hit_ist   ? {28'h000_0000, ist_q}   :
		hit_imask ? {28'h000_0000, imask_q} : 32'h0000_0000;

	// Side effects of status and data accesses
	wire rd_flags_w = rd_w && hit_flags;
	wire rx_clr_w   = rd_w && hit_data && rx_arm_q && rxf_q;
	wire tx_wr_w    = wr_w && hit_data && tx_arm_q && tx_full_q == 1'b0;
	wire ctrl_wr_w  = wr_w && hit_ctrl;

	////////////////////////////////////////////////////////////////////////
	// Engine decode
	wire fault_w = master_w && ctrl_q[SBR_CTRL_FEN] &&
		!ctrl_q[SBR_CTRL_SOE] && !sel_in_n;
	wire start_w = (state_q == SBR_IDLE) && !fault_w &&
		((master_w && tx_full_q) || (slave_w && !sel_in_n));
	wire abort_w = (state_q == SBR_SHIFT) &&
		(fault_w || !en_w || (slave_w && sel_in_n));
	wire half_tick;
	// Slave follows the peer clock, generated ticks unused there
	wire rise_w = master_w ? (half_tick && !sclk_q) : (sclk_in && !sclk_in_q);
	wire fall_w = master_w ? (half_tick && sclk_q) : (!sclk_in && sclk_in_q);
	wire edge_w = (state_q == SBR_SHIFT) && !abort_w && (rise_w || fall_w);
	wire last_w = edge_w && fall_w && (edge_q == SBR_EDGE_LAST);
	wire done_w = (state_q == SBR_FINISH);
	// Receive buffer still owned by software: drop new byte
	wire ovr_w  = done_w && rxf_q && !rx_clr_w;
	wire [7:0] load_w = tx_full_q ? tx_buf_q : 8'h00;

	sbr_baud_gen #(
		.PRE_W (3),
		.DIV_W (3)
	) u_baud (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.clk_en    (clk_en),
		.run       (master_w && state_q == SBR_SHIFT),
		.pre_sel   (rate_q[SBR_PRE_LSB +: 3]),
		.div_sel   (rate_q[SBR_DIV_LSB +: 3]),
		.half_tick (half_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// APB response and software registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (clk_en) begin
			pready_q  <= setup_w;
			pslverr_q <= setup_w && !mapped_w;
			if (setup_w)
				prdata_q <= pwrite ? 32'h0000_0000 : rdata_w;
		end
	end

	// Rate register writable in any mode, even mid-transfer
	// Flag register has no write path at all
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rate_q  <= SBR_RATE_RST;
			ctrl_q  <= SBR_CTRL_RST;
			imask_q <= SBR_IRQ_RST;
		end else if (clk_en && wr_w) begin
			if (hit_rate)
				rate_q <= pwdata[7:0] & SBR_RATE_MASK;
			if (hit_ctrl)
				ctrl_q <= pwdata[7:0] & SBR_CTRL_MASK;
			if (hit_imask)
				imask_q <= pwdata[3:0];
		end
	end

	// Sticky events; a new event wins over a same-cycle write-one clear
	wire [3:0] ev_w = {ovr_w, fault_w && !master_fault_flag_q,
		start_w && tx_full_q, done_w && !ovr_w};
	wire [3:0] w1c_w = (wr_w && hit_ist) ? pwdata[3:0] : 4'h0;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ist_q <= SBR_IRQ_RST;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			ist_q <= (ist_q & ~w1c_w) | ev_w;
			irq_q <= |(((ist_q & ~w1c_w) | ev_w) & imask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags, buffers and arming
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rxf_q      <= 1'b0;
			rx_buf_q   <= 8'h00;
			rx_arm_q   <= 1'b0;
			tx_arm_q   <= 1'b0;
			tx_full_q  <= 1'b0;
			tx_buf_q   <= 8'h00;
			master_fault_flag_q     <= 1'b0;
			master_fault_flag_arm_q <= 1'b0;
		end else if (clk_en) begin
			if (rd_flags_w) begin
				rx_arm_q   <= rxf_q;
				tx_arm_q   <= tef_w;
				master_fault_flag_arm_q <= master_fault_flag_q;
			end else begin
				if (rx_clr_w)
					rx_arm_q <= 1'b0;
				if (tx_wr_w)
					tx_arm_q <= 1'b0;
				if (ctrl_wr_w)
					master_fault_flag_arm_q <= 1'b0;
			end
			// Completion sets the flag; set wins over a clearing read
			if (done_w && !ovr_w) begin
				rxf_q    <= 1'b1;
				rx_buf_q <= shift_q;
			end else if (rx_clr_w) begin
				rxf_q <= 1'b0;
			end
			// Buffer frees on move to shifter, so empty flag rises
			if (tx_wr_w) begin
				tx_full_q <= 1'b1;
				tx_buf_q  <= pwdata[7:0];
			end else if (start_w) begin
				tx_full_q <= 1'b0;
			end
			if (fault_w)
				master_fault_flag_q <= 1'b1;
			else if (ctrl_wr_w && master_fault_flag_arm_q)
				master_fault_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shifter: sample on rising edge, shift on falling edge
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q   <= SBR_IDLE;
			shift_q   <= 8'h00;
			edge_q    <= 4'h0;
			rx_bit_q  <= 1'b0;
			sclk_q    <= 1'b0;
			sdo_q     <= 1'b0;
			sclk_in_q <= 1'b0;
		end else if (clk_en) begin
			sclk_in_q <= sclk_in;
			unique case (state_q)
				SBR_IDLE: begin
					sclk_q <= 1'b0;
					if (start_w) begin
						state_q <= SBR_SHIFT;
						shift_q <= load_w;
						sdo_q   <= load_w[7];
						edge_q  <= 4'h0;
					end
				end
				SBR_SHIFT: begin
					if (abort_w) begin
						state_q <= SBR_IDLE;
						sclk_q  <= 1'b0;
					end else if (edge_w) begin
						edge_q <= edge_q + 4'h1;
						if (master_w)
							sclk_q <= !sclk_q;
						if (rise_w) begin
							rx_bit_q <= sdi;
						end else begin
							shift_q <= {shift_q[6:0], rx_bit_q};
							sdo_q   <= shift_q[6];
						end
						if (last_w)
							state_q <= SBR_FINISH;
					end
				end
				SBR_FINISH: begin
					state_q <= SBR_IDLE;
				end
				default: begin
					state_q <= SBR_IDLE;
				end
			endcase
		end
	end

	// Pin drivers: clock and select only driven by a master
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sclk_oe_q   <= 1'b0;
			sel_oe_q    <= 1'b0;
			sel_out_n_q <= 1'b1;
		end else if (clk_en) begin
			sclk_oe_q   <= master_w;
			sel_oe_q    <= master_w && ctrl_q[SBR_CTRL_FEN] &&
				ctrl_q[SBR_CTRL_SOE];
			sel_out_n_q <= (state_q == SBR_IDLE) && !start_w;
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign sclk_out  = sclk_q;
	assign sclk_oe   = sclk_oe_q;
	assign sdo       = sdo_q;
	assign sel_out_n = sel_out_n_q;
	assign sel_oe    = sel_oe_q;
	assign irq       = irq_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_rate_any_time: assert property (
		clk_en && wr_w && hit_rate |=>
		rate_q == ($past(pwdata[7:0]) & SBR_RATE_MASK))
		else $error("rate write lost");
	a_flags_read_only: assert property (
		clk_en && wr_w && hit_flags && state_q == SBR_IDLE && !start_w &&
		!fault_w |=> $stable(rxf_q) && $stable(tx_full_q) && $stable(master_fault_flag_q))
		else $error("flag register changed by a write");
	a_flags_zero_bits: assert property (
		clk_en && setup_w && !pwrite && hit_flags |=>
		prdata[6] == 1'b0 && prdata[3:0] == 4'h0)
		else $error("reserved flag bits not zero");
	a_rx_full_set: assert property (
		clk_en && done_w && !rxf_q |=> rxf_q && rx_buf_q == $past(shift_q))
		else $error("receive-full not set at transfer end");
	a_rx_full_clear: assert property (
		$fell(rxf_q) |-> $past(rd_w && hit_data && rx_arm_q))
		else $error("receive-full cleared without flags-then-data read");
	a_overrun_drop: assert property (
		clk_en && ovr_w |=> $stable(rx_buf_q) && ist_q[SBR_IRQ_OVR])
		else $error("overrun did not keep old byte");
	a_tx_empty_load: assert property (
		clk_en && start_w && tx_full_q |=> tef_w && state_q == SBR_SHIFT)
		else $error("transmit-empty not set on load");
	a_fault_cause: assert property (
		$rose(master_fault_flag_q) |-> $past(master_w && ctrl_q[SBR_CTRL_FEN] &&
		!ctrl_q[SBR_CTRL_SOE] && !sel_in_n))
		else $error("mode fault without its conditions");
	a_slave_no_clock: assert property (
		clk_en && !master_w |=> !sclk_oe && !sclk_out)
		else $error("slave drives the serial clock");

	c_master_byte: cover property (master_w && done_w);
	c_slave_byte: cover property (slave_w && done_w);
	c_overrun: cover property (ovr_w);
	c_mode_fault: cover property ($rose(master_fault_flag_q));
endmodule // sbr_top
`default_nettype wire

// ===== testbench/sbr_slave_model.sv
// Purpose: Behavioural serial slave facing the master side of the port
// Assumes: Serial clock idles low; sample on rise, shift on fall, msb first
// Notes:   When deselected the data line toggles each cycle, never holds
`timescale 1ns/1ps
`default_nettype none
module sbr_slave_model (
	input  wire logic       ref_clk,
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	input  wire logic [7:0] reply,
	output logic            miso,
	output logic [7:0]      got
);
	logic       prev_q = 1'b0;
	logic       junk_q = 1'b0;
	logic [7:0] sh_q   = 8'h00;
	wire        fall_w = !sclk && prev_q;

	// A released line must not look like a valid last bit; the next bit
	// shows as soon as the clock falls, as a real slave's output would
	assign miso = sel_n ? junk_q : (fall_w ? sh_q[6] : sh_q[7]);

	always_ff @(posedge ref_clk) begin
		prev_q <= sclk;
		junk_q <= ~junk_q;
		if (sel_n) begin
			sh_q <= reply;
		end else begin
			if (sclk && !prev_q) begin
				got <= {got[6:0], mosi};
			end
			if (!sclk && prev_q) begin
				sh_q <= {sh_q[6:0], 1'b0};
			end
		end
	end
endmodule // sbr_slave_model
`default_nettype wire

// ===== testbench/sbr_top_tb.sv
// Purpose: APB-driven bench for rate generator, flags and byte shifter
// Assumes: One clock, clk_en held high, external serial clock unused
// Notes:   Only master transfers are exercised; slave shifting is not
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module sbr_top_tb;
	import sbr_pkg::*;
	logic        ref_clk = 1'b0;
	logic        nrst    = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic        sel_in_n = 1'b1;
	logic [7:0]  reply   = 8'h00;
	logic [31:0] prdata;
	logic        pready, pslverr, sclk_out, sclk_oe, sdo, sel_out_n;
	logic        sel_oe, irq, sdi;
	logic [7:0]  got;
	logic [31:0] rd;
	logic        last_err;
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          t1, t2;
	logic [7:0]  tx_tab [3] = '{8'hA5, 8'h3C, 8'h81};
	logic [6:0]  rate_tab [3] = '{7'h00, 7'h70, 7'h17};

	always #12.5 ref_clk = ~ref_clk;

	sbr_top sbr_top_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk_in(1'b0), .sdi(sdi), .sel_in_n(sel_in_n),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo(sdo),
		.sel_out_n(sel_out_n), .sel_oe(sel_oe), .irq(irq));
	sbr_slave_model sbr_slave_model_i (.ref_clk(ref_clk), .sclk(sclk_out),
		.mosi(sdo), .sel_n(sel_out_n), .reply(reply), .miso(sdi),
		.got(got));

	task automatic finish_test();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Request held until the edge where pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		// No wait limit here: only the watchdog ends a hung access
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, x);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, rd);
		`CHK(rd, e)
	endtask

	task automatic wait_rise(output int t);
		int n;
		logic p;
		n = 0;
		p = sclk_out;
		@(posedge ref_clk);
		while (!(sclk_out === 1'b1 && p === 1'b0) && n < 3000) begin
			p = sclk_out;
			@(posedge ref_clk);
			n++;
		end
		t = n;
	endtask

	// Poll interrupt status until the wanted bit shows, bounded
	task automatic wait_ist(input int b);
		int n;
		n = 0;
		rd = 32'h0000_0000;
		while (rd[b] !== 1'b1 && n < 3000) begin
			apb(1'b0, SBR_OFF_IST, 32'h0000_0000, rd);
			n++;
		end
		`CHK(rd[b], 1'b1)
	endtask

	task automatic send(input logic [7:0] b);
		rd_chk(SBR_OFF_FLAGS, 32'h0000_0020);
		wr(SBR_OFF_DATA, {24'h0000_00, b});
	endtask

	initial begin
		#(25ns * 60000);
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		rd_chk(SBR_OFF_RATE, 32'h0000_0000);
		rd_chk(SBR_OFF_FLAGS, 32'h0000_0020);
		wr(SBR_OFF_RATE, 32'h0000_00FF);
		rd_chk(SBR_OFF_RATE, 32'h0000_0077);
		wr(SBR_OFF_FLAGS, 32'h0000_00FF);
		rd_chk(SBR_OFF_FLAGS, 32'h0000_0020);
		apb(1'b0, 8'h40, 32'h0000_0000, rd);
		`CHK(last_err, 1'b1)
		`CHK(rd, 32'h0000_0000)
		`CHK(sclk_oe, 1'b0)
		wr(SBR_OFF_CTRL, 32'h0000_0050);
		repeat (2) @(posedge ref_clk);
		`CHK(sclk_oe, 1'b1)
		wr(SBR_OFF_IMASK, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			wr(SBR_OFF_RATE, {25'h0, rate_tab[i]});
			reply <= ~tx_tab[i];
			send(tx_tab[i]);
			repeat (2) @(posedge ref_clk);
			`CHK(sel_out_n, 1'b0)
			wait_rise(t1);
			wait_rise(t2);
			`CHK(t2 + 1, 2 * (rate_tab[i][6:4] + 1) * (2 ** rate_tab[i][2:0]))
			wait_ist(SBR_IRQ_RX);
			@(posedge ref_clk);
			`CHK(irq, 1'b1)
			`CHK(got, tx_tab[i])
			rd_chk(SBR_OFF_FLAGS, 32'h0000_00A0);
			rd_chk(SBR_OFF_DATA, {24'h0000_00, ~tx_tab[i]});
			rd_chk(SBR_OFF_FLAGS, 32'h0000_0020);
			wr(SBR_OFF_IST, 32'h0000_000F);
			@(posedge ref_clk);
			`CHK(irq, 1'b0)
		end
		wr(SBR_OFF_RATE, 32'h0000_0000);
		reply <= 8'h5A;
		send(8'h11);
		wait_ist(SBR_IRQ_RX);
		wr(SBR_OFF_IST, 32'h0000_000F);
		reply <= 8'hC3;
		rd_chk(SBR_OFF_FLAGS, 32'h0000_00A0);
		wr(SBR_OFF_DATA, 32'h0000_0022);
		wait_ist(SBR_IRQ_OVR);
		rd_chk(SBR_OFF_FLAGS, 32'h0000_00A0);
		rd_chk(SBR_OFF_DATA, 32'h0000_005A);
		wr(SBR_OFF_CTRL, 32'h0000_005A);
		sel_in_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		`CHK(sel_oe, 1'b1)
		rd_chk(SBR_OFF_FLAGS, 32'h0000_0020);
		wr(SBR_OFF_CTRL, 32'h0000_0058);
		repeat (4) @(posedge ref_clk);
		rd_chk(SBR_OFF_FLAGS, 32'h0000_0030);
		sel_in_n <= 1'b1;
		finish_test();
	end
endmodule // sbr_top_tb
`default_nettype wire
